// file: hdl/interrupt_entry_return.sv
// Interrupt and exception handler entry and return sequencer
// What this block does
// - Vector selects an interrupt-type or trap-type gate; handler entered through it.
// - Gate supplies access rights, handler code selector and handler offset.
// - Interrupt-type gate entry clears the interrupt enable flag.
// - Trap-type gate entry leaves the interrupt enable flag unchanged.
// - Vectors 0 divide, 1 debug, 2 non-maskable, 3 breakpoint, 4 overflow.
// - Vector 5 bound range, vector 6 invalid or reserved opcode.
// - Vector 7 math unit unavailable; vector 9 reserved, never raised.
// - Vector 8 double fault.
// - Vector 10 bad task state area, vector 11 segment absent.
// - Vector 12 stack fault, 13 protection fault, 14 page fault.
// - Vector 16 math, 17 alignment, 18 machine check, 19 SIMD.
// - Vectors 15, 20-31 reserved; 32-255 maskable external or software.
// - Same privilege keeps stack; more privileged handler switches stacks.
// - No switch: push flags, selector, pointer, error code, load gate, start.
// - Switch: hold old state, load new stack from task state area.
// - Switch: push held stack selector, pointer, flags, selector, pointer, error.
// - Switch: load gate selector and pointer, clear flag for interrupt-type gate, run at new level.
// - Return restores flags as well as code selector and pointer.
// - Same-level return restores selector, pointer, flags and pops the frame.
// - Cross-level return checks privilege, then restores state and old stack.
// - Predefined vectors 0-8, 10-14, 16-19; 32-255 index descriptor entries.
`timescale 1ns/1ns
`default_nettype none
`include "irq_seq_map.svh"
module interrupt_entry_return
	import irq_seq_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire cpu_state_t i_cur,
	input wire logic [1:0] i_cpl,
	input wire event_t i_event,
	input wire logic [31:0] i_err,
	input wire logic i_maskable_request_pin,
	input wire logic [7:0] i_ext_vector,
	input wire logic i_return_from_interrupt,
	output logic o_gate_rd,
	output logic [7:0] o_gate_vector,
	input wire logic i_gate_vld,
	input wire gate_t i_gate,
	output logic o_tss_rd,
	output logic [1:0] o_tss_level,
	input wire logic i_tss_vld,
	input wire logic [15:0] i_tss_ss,
	input wire logic [31:0] i_tss_sp,
	output logic o_mem_wr,
	output logic o_mem_rd,
	output logic [31:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	output logic o_busy,
	output logic o_load,
	output cpu_state_t o_new,
	output logic [1:0] o_new_cpl,
	output logic o_priv_error
);
	// ----------------------------------------
	// Vector selection
	// ----------------------------------------
	logic [7:0] exc_vector;
	logic exc_err;
	vector_encoder u_enc (
		.i_event(i_event),
		.o_vector(exc_vector),
		.o_err_code(exc_err)
	);
	wire exc_req = (i_event != EV_NONE);
	wire irq_req = i_maskable_request_pin && i_cur.flags[`IF_BIT];
	// Only 32-255 taken from the pin
	wire ext_ok = (i_ext_vector >= `V_USER_FIRST);
	seq_state_t state_q, state_d;
	cpu_state_t held_q;
	gate_t gate_q;
	logic [7:0] vec_q;
	logic err_q, switch_q, ret_q, cross_q;
	logic [31:0] err_val_q, sp_q;
	logic [15:0] ss_q;
	logic [2:0] slot_q, last_q;
	logic [1:0] cpl_q;
	logic [31:0] pop_q [0:4];
	logic [31:0] push_word;
	// ----------------------------------------
	// Frame word selection
	// ----------------------------------------
	frame_builder u_frame (
		.i_held(held_q),
		.i_switch(switch_q),
		.i_slot(slot_q),
		.i_err(err_val_q),
		.o_word(push_word)
	);
	// More privileged handler needs a new stack
	wire need_switch = i_gate.dpl < cpl_q;
	wire [2:0] frame_len = need_switch ? `FRAME_SWITCH : `FRAME_SAME;
	wire [2:0] push_last = err_q ? frame_len : frame_len - 3'd1;
	// Return level is popped code selector privilege
	wire [1:0] ret_rpl = pop_q[1][1:0];
	wire ret_cross = ret_rpl != cpl_q;
	wire ret_bad = ret_rpl < cpl_q;
	wire pop_end = (slot_q == last_q) || (slot_q == 3'd2 && !ret_cross);
	wire [31:0] sp_dec = sp_q - `ENTRY_BYTES;
	wire [31:0] sp_inc = sp_q + `ENTRY_BYTES;
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (i_return_from_interrupt) begin
					state_d = ST_POP;
				end else if (exc_req || (irq_req && ext_ok)) begin
					state_d = ST_GATE;
				end
			end
			ST_GATE: begin
				if (i_gate_vld) begin
					state_d = need_switch ? ST_TSS : ST_PUSH;
				end
			end
			ST_TSS: begin
				if (i_tss_vld) begin
					state_d = ST_PUSH;
				end
			end
			ST_PUSH: begin
				if (i_mem_ack && slot_q == last_q) begin
					state_d = ST_DONE;
				end
			end
			ST_POP: begin
				if (i_mem_ack && pop_end) begin
					state_d = ST_DONE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end
	// ----------------------------------------
	// Request capture and held state
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			vec_q <= 8'h00;
			err_q <= 1'b0;
			err_val_q <= 32'h0000_0000;
			held_q <= '0;
			cpl_q <= 2'h0;
			ret_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			held_q <= i_cur;
			cpl_q <= i_cpl;
			err_val_q <= i_err;
			ret_q <= i_return_from_interrupt;
			vec_q <= exc_req ? exc_vector : i_ext_vector;
			err_q <= exc_req && exc_err;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			gate_q <= '0;
			switch_q <= 1'b0;
		end else if (state_q == ST_GATE && i_gate_vld) begin
			gate_q <= i_gate;
			switch_q <= need_switch;
		end else if (state_q == ST_IDLE) begin
			switch_q <= 1'b0;
		end
	end
	// ----------------------------------------
	// Stack pointer and slot walk
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			sp_q <= 32'h0000_0000;
			ss_q <= 16'h0000;
			slot_q <= 3'h0;
			last_q <= 3'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					sp_q <= i_cur.sp;
					ss_q <= i_cur.ss;
					slot_q <= 3'h0;
					last_q <= `FRAME_SWITCH - 3'd1;
				end
				ST_GATE: begin
					last_q <= push_last;
					if (i_gate_vld && !need_switch) begin
						sp_q <= sp_dec;
					end
				end
				ST_TSS: begin
					// New stack from task state area
					if (i_tss_vld) begin
						ss_q <= i_tss_ss;
						sp_q <= i_tss_sp - `ENTRY_BYTES;
					end
				end
				ST_PUSH: begin
					if (i_mem_ack) begin
						slot_q <= slot_q + 3'd1;
						if (slot_q != last_q) begin
							sp_q <= sp_dec;
						end
					end
				end
				ST_POP: begin
					if (i_mem_ack) begin
						slot_q <= slot_q + 3'd1;
						sp_q <= sp_inc;
						if (slot_q == 3'd2 && !ret_cross) begin
							last_q <= 3'd2;
						end
					end
				end
				default: begin
					slot_q <= 3'h0;
				end
			endcase
		end
	end
	// Popped words: ip, cs, flags, sp, ss
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_pop
			always_ff @(posedge i_clk_sys) begin
				if (i_srst) begin
					pop_q[gi] <= 32'h0000_0000;
				end else if (state_q == ST_POP && i_mem_ack && slot_q == 3'(gi)) begin
					pop_q[gi] <= i_mem_rdata;
				end
			end
		end
	endgenerate
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			cross_q <= 1'b0;
		end else if (state_q == ST_POP && i_mem_ack && slot_q == 3'd2) begin
			cross_q <= ret_cross;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	cpu_state_t entry_state, ret_state;
	logic [31:0] entry_flags;
	always_comb begin
		entry_flags = held_q.flags;
		if (!gate_q.trap_type) begin
			entry_flags[`IF_BIT] = 1'b0;
		end
		// Handler selector and pointer from gate
		entry_state = '{flags: entry_flags, cs: gate_q.code_sel, ip: gate_q.offset,
			ss: ss_q, sp: sp_q};
		// Flags restored with selector and pointer
		ret_state = '{flags: pop_q[2], cs: pop_q[1][15:0], ip: pop_q[0],
			ss: cross_q ? pop_q[4][15:0] : held_q.ss, sp: cross_q ? pop_q[3] : sp_q};
	end
	wire done = state_q == ST_DONE;
	// First pop address is the live stack pointer
	wire [31:0] mem_addr_d = (state_q == ST_IDLE) ? i_cur.sp : sp_q;
	// Level held from the valid gate
	wire [1:0] tss_level_d = (state_q == ST_GATE && i_gate_vld) ? i_gate.dpl : o_tss_level;
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_gate_rd <= 1'b0;
			o_gate_vector <= 8'h00;
			o_tss_rd <= 1'b0;
			o_tss_level <= 2'h0;
			o_mem_wr <= 1'b0;
			o_mem_rd <= 1'b0;
			o_mem_addr <= 32'h0000_0000;
			o_mem_wdata <= 32'h0000_0000;
			o_busy <= 1'b0;
			o_load <= 1'b0;
			o_new <= '0;
			o_new_cpl <= 2'h0;
			o_priv_error <= 1'b0;
		end else begin
			o_gate_rd <= state_d == ST_GATE;
			o_gate_vector <= (state_q == ST_IDLE) ? (exc_req ? exc_vector : i_ext_vector) : vec_q;
			o_tss_rd <= state_d == ST_TSS;
			o_tss_level <= tss_level_d;
			// Pushes on the current or new stack
			// Strobe rests one cycle after each ack
			o_mem_wr <= state_q == ST_PUSH && !i_mem_ack;
			o_mem_rd <= state_d == ST_POP && !i_mem_ack;
			o_mem_addr <= mem_addr_d;
			o_mem_wdata <= push_word;
			o_busy <= state_d != ST_IDLE;
			o_load <= done && !(ret_q && cross_q && ret_bad);
			o_new <= ret_q ? ret_state : entry_state;
			o_new_cpl <= ret_q ? pop_q[1][1:0] : (switch_q ? gate_q.dpl : cpl_q);
			// Return to a more privileged level refused
			o_priv_error <= done && ret_q && cross_q && ret_bad;
		end
	end
endmodule
`default_nettype wire

// file: hdl/irq_seq_map.svh
// Constants for the interrupt entry and return sequencer
`ifndef IRQ_SEQ_MAP_SVH
`define IRQ_SEQ_MAP_SVH
`define V_QUOTIENT 8'h00
`define V_DEBUG 8'h01
`define V_NMI 8'h02
`define V_BREAKPOINT 8'h03
`define V_OVERFLOW 8'h04
`define V_BOUND 8'h05
`define V_INVALID_OP 8'h06
`define V_NO_MATH 8'h07
`define V_DOUBLE 8'h08
`define V_SEG_OVERRUN 8'h09
`define V_BAD_TASK_STATE 8'h0a
`define V_SEG_ABSENT 8'h0b
`define V_STACK_FAULT 8'h0c
`define V_PROTECTION 8'h0d
`define V_PAGE 8'h0e
`define V_RSVD15 8'h0f
`define V_MATH 8'h10
`define V_ALIGN 8'h11
`define V_MACHINE_CHECK 8'h12
`define V_SIMD 8'h13
`define V_RSVD_LAST 8'h1f
`define V_USER_FIRST 8'h20
`define IF_BIT 9
`define ENTRY_BYTES 32'h0000_0004
`define ERRCODE_VEC_MASK 32'h0002_7d00
`define FRAME_SAME 3'h3
`define FRAME_SWITCH 3'h5
`endif

// file: hdl/irq_seq_pkg.sv
// Types for the interrupt entry and return sequencer
package irq_seq_pkg;
	typedef struct packed {
		logic trap_type;
		logic [1:0] dpl;
		logic present;
		logic [15:0] code_sel;
		logic [31:0] offset;
	} gate_t;
	typedef struct packed {
		logic [31:0] flags;
		logic [15:0] cs;
		logic [31:0] ip;
		logic [15:0] ss;
		logic [31:0] sp;
	} cpu_state_t;
	typedef enum logic [4:0] {
		EV_NONE, EV_QUOTIENT, EV_DEBUG, EV_NMI, EV_BREAKPOINT, EV_OVERFLOW, EV_BOUND,
		EV_INVALID_OP, EV_NO_MATH, EV_DOUBLE, EV_BAD_TASK_STATE, EV_SEG_ABSENT,
		EV_STACK_FAULT, EV_PROTECTION, EV_PAGE, EV_MATH, EV_ALIGN, EV_MACHINE_CHECK,
		EV_SIMD
	} event_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_GATE, ST_TSS, ST_PUSH, ST_POP, ST_DONE
	} seq_state_t;
endpackage

// file: hdl/vector_encoder.sv
// Maps internal fault events to their vector numbers
`timescale 1ns/1ns
`default_nettype none
`include "irq_seq_map.svh"
module vector_encoder
	import irq_seq_pkg::*;
(
	input wire event_t i_event,
	output logic [7:0] o_vector,
	output logic o_err_code
);
	always_comb begin
		case (i_event)
			EV_QUOTIENT: o_vector = `V_QUOTIENT;
			EV_DEBUG: o_vector = `V_DEBUG;
			EV_NMI: o_vector = `V_NMI;
			EV_BREAKPOINT: o_vector = `V_BREAKPOINT;
			EV_OVERFLOW: o_vector = `V_OVERFLOW;
			EV_BOUND: o_vector = `V_BOUND;
			EV_INVALID_OP: o_vector = `V_INVALID_OP;
			EV_NO_MATH: o_vector = `V_NO_MATH;
			EV_DOUBLE: o_vector = `V_DOUBLE;
			EV_BAD_TASK_STATE: o_vector = `V_BAD_TASK_STATE;
			EV_SEG_ABSENT: o_vector = `V_SEG_ABSENT;
			EV_STACK_FAULT: o_vector = `V_STACK_FAULT;
			EV_PROTECTION: o_vector = `V_PROTECTION;
			EV_PAGE: o_vector = `V_PAGE;
			EV_MATH: o_vector = `V_MATH;
			EV_ALIGN: o_vector = `V_ALIGN;
			EV_MACHINE_CHECK: o_vector = `V_MACHINE_CHECK;
			EV_SIMD: o_vector = `V_SIMD;
			default: o_vector = `V_QUOTIENT;
		endcase
	end
	wire [31:0] err_mask = `ERRCODE_VEC_MASK;
	assign o_err_code = (o_vector < `V_USER_FIRST) ? err_mask[o_vector[4:0]] : 1'b0;
endmodule
`default_nettype wire

// file: hdl/frame_builder.sv
// Selects the stack word for each push slot of an entry frame
`timescale 1ns/1ns
`default_nettype none
module frame_builder
	import irq_seq_pkg::*;
(
	input wire cpu_state_t i_held,
	input wire logic i_switch,
	input wire logic [2:0] i_slot,
	input wire logic [31:0] i_err,
	output logic [31:0] o_word
);
	logic [2:0] idx;
	always_comb begin
		idx = i_switch ? i_slot : i_slot + 3'd2;
		case (idx)
			3'd0: o_word = {16'h0000, i_held.ss};
			3'd1: o_word = i_held.sp;
			3'd2: o_word = i_held.flags;
			3'd3: o_word = {16'h0000, i_held.cs};
			3'd4: o_word = i_held.ip;
			default: o_word = i_err;
		endcase
	end
endmodule
`default_nettype wire

// file: verification/irq_seq_assertions.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module irq_seq_checker
	import irq_seq_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire cpu_state_t i_cur,
	input wire event_t i_event,
	input wire logic i_maskable_request_pin,
	input wire logic [7:0] i_ext_vector,
	input wire logic i_return_from_interrupt,
	input wire logic o_gate_rd,
	input wire logic [7:0] o_gate_vector,
	input wire logic i_gate_vld,
	input wire gate_t i_gate,
	input wire logic o_mem_wr,
	input wire logic o_mem_rd,
	input wire logic [31:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic o_busy,
	input wire logic o_load,
	input wire cpu_state_t o_new,
	input wire logic o_priv_error
);
	// ----------------------------------------
	// Entry tracking and properties
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	logic entry_q;
	logic trap_q;
	logic if_q;
	gate_t gate_q;
	wire logic pin_idle = !o_busy && i_event == EV_NONE && !i_return_from_interrupt
		&& i_maskable_request_pin;
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			entry_q <= 1'b0;
		end else if (i_gate_vld && o_gate_rd) begin
			entry_q <= 1'b1;
			trap_q <= i_gate.trap_type;
			if_q <= i_cur.flags[9];
			gate_q <= i_gate;
		end else if (o_load) begin
			entry_q <= 1'b0;
		end
	end
	sequence s_push_acked;
		o_mem_wr && i_mem_ack;
	endsequence
	sequence s_pop_acked;
		o_mem_rd && i_mem_ack;
	endsequence
	a_gate_on_event: assert property (
		!o_busy && !i_return_from_interrupt && i_event != EV_NONE |=> o_gate_rd && o_busy)
		else $error("no gate fetch after event");
	a_pin_vector: assert property (
		pin_idle && i_cur.flags[9] && i_ext_vector >= 8'h20
		|=> o_gate_rd && o_gate_vector == $past(i_ext_vector))
		else $error("pin request not taken with its vector");
	a_pin_refused: assert property (
		pin_idle && (!i_cur.flags[9] || i_ext_vector < 8'h20) |=> !o_busy)
		else $error("masked pin request taken");
	a_no_vector9: assert property (o_gate_rd |-> o_gate_vector != 8'h09)
		else $error("reserved vector raised");
	a_if_cleared: assert property (
		o_load && entry_q && !trap_q |-> !o_new.flags[9])
		else $error("enable flag kept on interrupt gate");
	a_if_kept: assert property (
		o_load && entry_q && trap_q |-> o_new.flags[9] == if_q)
		else $error("enable flag changed on trap gate");
	a_gate_target: assert property (
		o_load && entry_q |-> o_new.cs == gate_q.code_sel && o_new.ip == gate_q.offset)
		else $error("handler target not from gate");
	a_push_step: assert property (
		s_push_acked ##1 !o_mem_wr ##1 o_mem_wr |-> o_mem_addr == $past(o_mem_addr, 2) - 32'h4)
		else $error("push address step wrong");
	a_pop_step: assert property (
		s_pop_acked ##1 !o_mem_rd ##1 o_mem_rd |-> o_mem_addr == $past(o_mem_addr, 2) + 32'h4)
		else $error("pop address step wrong");
	a_strobe_hold: assert property (
		o_mem_wr && !i_mem_ack |=> o_mem_wr && $stable(o_mem_addr))
		else $error("write strobe dropped before ack");
	a_entry_bound: assert property ($rose(o_gate_rd) |-> ##[2:200] o_load)
		else $error("entry did not complete");
	a_refuse_no_load: assert property (o_priv_error |-> !o_load)
		else $error("refused return still loaded");
endmodule
`default_nettype wire

// file: verification/stack_gate_partner.sv
// Gate table, task state area and stack memory model
`timescale 1ns/1ns
`default_nettype none
module stack_gate_partner
	import irq_seq_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic [1:0] i_slow,
	input wire logic [1:0] i_hlvl,
	input wire logic i_gate_rd,
	input wire logic [7:0] i_gate_vector,
	output logic o_gate_vld,
	output gate_t o_gate,
	input wire logic i_tss_rd,
	input wire logic [1:0] i_tss_level,
	output logic o_tss_vld,
	output logic [15:0] o_tss_ss,
	output logic [31:0] o_tss_sp,
	input wire logic i_mem_wr,
	input wire logic i_mem_rd,
	input wire logic [31:0] i_mem_addr,
	input wire logic [31:0] i_mem_wdata,
	output logic o_mem_ack,
	output logic [31:0] o_mem_rdata
);
	// ----------------------------------------
	// Answers with a delay of i_slow cycles
	// ----------------------------------------
	logic [31:0] mem [logic [31:0]];
	logic [1:0] gcnt_q = 2'h0;
	logic [1:0] tcnt_q = 2'h0;
	logic [1:0] mcnt_q = 2'h0;
	initial begin
		o_gate_vld = 1'b0;
		o_gate = '0;
		o_tss_vld = 1'b0;
		o_tss_ss = 16'h0000;
		o_tss_sp = 32'h0000_0000;
		o_mem_ack = 1'b0;
		o_mem_rdata = 32'h0000_0000;
	end
	always @(posedge i_clk_sys) begin
		o_gate_vld <= 1'b0;
		o_tss_vld <= 1'b0;
		o_mem_ack <= 1'b0;
		o_gate <= ~o_gate;
		o_tss_ss <= ~o_tss_ss;
		o_tss_sp <= ~o_tss_sp;
		o_mem_rdata <= ~o_mem_rdata;
		if (i_gate_rd && !o_gate_vld) begin
			gcnt_q <= gcnt_q + 2'h1;
			if (gcnt_q == i_slow) begin
				gcnt_q <= 2'h0;
				o_gate_vld <= 1'b1;
				o_gate <= '{i_gate_vector[0], i_hlvl, 1'b1, {8'h40, i_gate_vector[5:0], i_hlvl},
					{24'h001000, i_gate_vector}};
			end
		end
		if (i_tss_rd && !o_tss_vld) begin
			tcnt_q <= tcnt_q + 2'h1;
			if (tcnt_q == i_slow) begin
				tcnt_q <= 2'h0;
				o_tss_vld <= 1'b1;
				o_tss_ss <= {14'h002a, i_tss_level};
				o_tss_sp <= 32'h0000_8000;
			end
		end
		if ((i_mem_wr || i_mem_rd) && !o_mem_ack) begin
			mcnt_q <= mcnt_q + 2'h1;
			if (mcnt_q == i_slow) begin
				mcnt_q <= 2'h0;
				o_mem_ack <= 1'b1;
				if (i_mem_wr) begin
					mem[i_mem_addr] = i_mem_wdata;
				end else begin
					o_mem_rdata <= mem[i_mem_addr];
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the entry and return sequencer
`timescale 1ns/1ns
`default_nettype none
bind interrupt_entry_return irq_seq_checker u_irq_seq_checker (.i_clk_sys, .i_srst, .i_cur,
	.i_event, .i_maskable_request_pin, .i_ext_vector, .i_return_from_interrupt, .o_gate_rd,
	.o_gate_vector, .i_gate_vld, .i_gate, .o_mem_wr, .o_mem_rd, .o_mem_addr, .i_mem_ack,
	.o_busy, .o_load, .o_new, .o_priv_error);
module testbench
	import irq_seq_pkg::*;
;
	// ----------------------------------------
	// Stimulus and judging
	// ----------------------------------------
	logic i_clk_sys, i_srst, i_maskable_request_pin, i_return_from_interrupt, i_gate_vld;
	logic i_tss_vld, i_mem_ack, o_gate_rd, o_tss_rd, o_mem_wr, o_mem_rd, o_busy, o_load;
	logic o_priv_error;
	logic [1:0] i_cpl, o_tss_level, o_new_cpl, slow, hlvl;
	logic [7:0] i_ext_vector, o_gate_vector;
	logic [15:0] i_tss_ss;
	logic [31:0] i_err, i_tss_sp, o_mem_addr, o_mem_wdata, i_mem_rdata;
	cpu_state_t i_cur, o_new;
	event_t i_event;
	gate_t i_gate;
	int fail_count = 0;
	int total_checks = 0;
	localparam logic [7:0] VEC_TAB [18] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
		8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h13};
	interrupt_entry_return u_interrupt_entry_return (.i_clk_sys, .i_srst, .i_cur, .i_cpl,
		.i_event, .i_err, .i_maskable_request_pin, .i_ext_vector, .i_return_from_interrupt,
		.o_gate_rd, .o_gate_vector, .i_gate_vld, .i_gate, .o_tss_rd, .o_tss_level, .i_tss_vld,
		.i_tss_ss, .i_tss_sp, .o_mem_wr, .o_mem_rd, .o_mem_addr, .o_mem_wdata, .i_mem_ack,
		.i_mem_rdata, .o_busy, .o_load, .o_new, .o_new_cpl, .o_priv_error);
	stack_gate_partner u_stack_gate_partner (.i_clk_sys(i_clk_sys), .i_slow(slow),
		.i_hlvl(hlvl), .i_gate_rd(o_gate_rd), .i_gate_vector(o_gate_vector),
		.o_gate_vld(i_gate_vld), .o_gate(i_gate), .i_tss_rd(o_tss_rd),
		.i_tss_level(o_tss_level), .o_tss_vld(i_tss_vld), .o_tss_ss(i_tss_ss),
		.o_tss_sp(i_tss_sp), .i_mem_wr(o_mem_wr), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
		.i_mem_wdata(o_mem_wdata), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_done(output logic pe);
		int k;
		for (k = 0; k < 300; k++) begin
			@(negedge i_clk_sys);
			if (o_load === 1'b1 || o_priv_error === 1'b1) break;
		end
		pe = o_priv_error === 1'b1;
		if (k == 300) begin
			check("completion", 32'h0, 32'h1);
			summarize();
		end
	endtask
	task automatic do_entry(input event_t ev, input logic pin, input logic [7:0] vec,
		input logic [1:0] cpl, input logic [1:0] hl, input logic [7:0] v);
		logic e, sw, pe;
		logic [31:0] base;
		logic [31:0] w [6];
		cpu_state_t c;
		c = '{32'h0000_0202, {14'h0006, cpl}, 32'h0040_1234, 16'h0023, 32'h0000_7000};
		e = ev != EV_NONE && (v == 8'h08 || (v >= 8'h0a && v <= 8'h0e) || v == 8'h11);
		sw = hl < cpl;
		base = sw ? 32'h0000_8000 : c.sp;
		if (sw) w = '{c.ss, c.sp, c.flags, c.cs, c.ip, i_err};
		else w = '{c.flags, c.cs, c.ip, i_err, 32'h0, 32'h0};
		@(negedge i_clk_sys);
		i_cur = c;
		i_cpl = cpl;
		hlvl = hl;
		i_event = ev;
		i_maskable_request_pin = pin;
		i_ext_vector = vec;
		@(negedge i_clk_sys);
		i_event = EV_NONE;
		i_maskable_request_pin = 1'b0;
		check("vector", o_gate_vector, v);
		wait_done(pe);
		for (int i = 0; i < (sw ? 5 : 3) + e; i++) begin
			check("frame", u_stack_gate_partner.mem[base - 32'h4 * (i + 1)], w[i]);
		end
		check("sp", o_new.sp, base - 32'h4 * ((sw ? 5 : 3) + e));
		check("flags", o_new.flags, v[0] ? c.flags : c.flags & ~32'h200);
		check("cs", o_new.cs, {8'h40, v[5:0], hl});
		check("ip", o_new.ip, {24'h001000, v});
		check("ss", o_new.ss, sw ? {14'h002a, hl} : c.ss);
		check("cpl", o_new_cpl, hl);
	endtask
	task automatic do_refuse(input logic [7:0] vec, input logic [31:0] fl);
		@(negedge i_clk_sys);
		i_cur.flags = fl;
		i_ext_vector = vec;
		i_maskable_request_pin = 1'b1;
		@(negedge i_clk_sys);
		i_maskable_request_pin = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		check("busy", o_busy, 1'b0);
	endtask
	task automatic do_ret(input logic [1:0] cpl, input logic [1:0] rpl);
		logic pe;
		logic same;
		same = rpl == cpl;
		u_stack_gate_partner.mem[32'h6000] = 32'h0040_5678;
		u_stack_gate_partner.mem[32'h6004] = {16'h0, 14'h0006, rpl};
		u_stack_gate_partner.mem[32'h6008] = 32'h0000_0246;
		u_stack_gate_partner.mem[32'h600c] = 32'h0000_7ff0;
		u_stack_gate_partner.mem[32'h6010] = 32'h0000_002b;
		@(negedge i_clk_sys);
		i_cur = '{32'h0000_0002, {14'h0008, cpl}, 32'h0010_0000, 16'h0010, 32'h0000_6000};
		i_cpl = cpl;
		i_return_from_interrupt = 1'b1;
		@(negedge i_clk_sys);
		i_return_from_interrupt = 1'b0;
		wait_done(pe);
		check("refused", pe, rpl < cpl);
		if (rpl >= cpl) begin
			check("ret_ip", o_new.ip, 32'h0040_5678);
			check("ret_cs", o_new.cs, {14'h0006, rpl});
			check("ret_flags", o_new.flags, 32'h0000_0246);
			check("ret_sp", o_new.sp, same ? 32'h0000_600c : 32'h0000_7ff0);
			check("ret_ss", o_new.ss, same ? 16'h0010 : 16'h002b);
		end
	endtask
	initial begin
		i_srst = 1'b1;
		i_cur = '0;
		i_cpl = 2'h0;
		i_event = EV_NONE;
		i_err = 32'h0000_5a5a;
		i_maskable_request_pin = 1'b0;
		i_ext_vector = 8'h00;
		i_return_from_interrupt = 1'b0;
		slow = 2'h0;
		hlvl = 2'h0;
		repeat (12) @(negedge i_clk_sys);
		i_srst = 1'b0;
		for (int k = 0; k < 18; k++) begin
			slow = (k % 2) ? 2'h3 : 2'h0;
			do_entry(event_t'(k + 1), 1'b0, 8'h00, 2'h0, 2'h0, VEC_TAB[k]);
		end
		do_entry(EV_NONE, 1'b1, 8'h30, 2'h0, 2'h0, 8'h30);
		do_entry(EV_NONE, 1'b1, 8'hff, 2'h0, 2'h0, 8'hff);
		do_refuse(8'h1f, 32'h0000_0202);
		do_refuse(8'h30, 32'h0000_0002);
		do_entry(EV_PROTECTION, 1'b0, 8'h00, 2'h3, 2'h0, 8'h0d);
		do_entry(EV_NONE, 1'b1, 8'h41, 2'h3, 2'h1, 8'h41);
		do_ret(2'h0, 2'h0);
		do_ret(2'h0, 2'h3);
		do_ret(2'h3, 2'h0);
		summarize();
	end
endmodule
`default_nettype wire
